/* design/line_perf_counters.sv */
// Four line performance error counters with an AXI4-Lite register slave.
// Assumes receive-side strobes come from logic on CLK; the update pin is asynchronous.
`timescale 1ns/1ps
module line_perf_counters
  import perf_cnt_pkg::*;
#(
  parameter int UPDATE_CYCLES_P = UPDATE_CYCLES
)
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic RX_BIT_EN,
  input wire logic RX_POS,
  input wire logic RX_NEG,
  input wire logic RX_ZS_CODEWORD,
  input wire logic MF_DONE,
  input wire logic MF_FAS_OK,
  input wire logic FBIT_ERR,
  input wire logic CRC_ERR,
  input wire logic COUNTER_UPDATE_PIN,
  output logic LOF_STATE,
  input wire logic [AXI_AW-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [AXI_DW-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [AXI_AW-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [AXI_DW-1:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  // ==========================================================
  // Update pin synchroniser and edge
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= COUNTER_UPDATE_PIN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ==========================================================
  // Control register
  logic auto_q;
  logic auto_d;
  logic select_q;
  logic select_d;
  logic gate_q;
  logic gate_d;
  logic manual_q;
  logic manual_d;
  logic wr_fire;
  logic [AXI_AW-1:0] waddr_q;
  logic [AXI_DW-1:0] wdata_q;
  logic [3:0] wstrb_q;

  always_comb
  begin
    auto_d = auto_q;
    select_d = select_q;
    gate_d = gate_q;
    manual_d = 1'b0;
    if (wr_fire && waddr_q == byte_addr(IDX_CTRL) && wstrb_q[0])
    begin
      auto_d = wdata_q[CTRL_AUTO_BIT];
      select_d = wdata_q[CTRL_SELECT_BIT];
      gate_d = wdata_q[CTRL_GATE_BIT];
      manual_d = wdata_q[CTRL_MANUAL_BIT];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      auto_q <= CTRL_AUTO_RST;
      select_q <= CTRL_SELECT_RST;
      gate_q <= CTRL_GATE_RST;
      manual_q <= 1'b0;
    end
    else
    begin
      auto_q <= auto_d;
      select_q <= select_d;
      gate_q <= gate_d;
      manual_q <= manual_d;
    end
  end

  // ==========================================================
  // Update event: one-second timer, or manual command or update pin rising edge
  logic [31:0] tmr_q;
  logic [31:0] tmr_d;
  logic upd_q;
  logic upd_d;

  always_comb
  begin
    tmr_d = tmr_q;
    upd_d = 1'b0;
    if (auto_q)
    begin
      if (tmr_q == 32'(UPDATE_CYCLES_P - 1))
      begin
        tmr_d = 32'h0;
        upd_d = 1'b1;
      end
      else
      begin
        tmr_d = tmr_q + 32'h1;
      end
    end
    else
    begin
      tmr_d = 32'h0;
      upd_d = manual_q || (pin_s2_q && !pin_s3_q);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      tmr_q <= 32'h0;
      upd_q <= 1'b0;
    end
    else
    begin
      tmr_q <= tmr_d;
      upd_q <= upd_d;
    end
  end

  // ==========================================================
  // Line event detection
  logic last_pos_q;
  logic last_pos_d;
  logic seen_mark_q;
  logic seen_mark_d;
  logic [3:0] zrun_q;
  logic [3:0] zrun_d;
  logic bpv_q;
  logic bpv_d;
  logic exz_q;
  logic exz_d;
  logic mark;

  always_comb
  begin
    mark = RX_POS || RX_NEG;
    last_pos_d = last_pos_q;
    seen_mark_d = seen_mark_q;
    zrun_d = zrun_q;
    bpv_d = 1'b0;
    exz_d = 1'b0;
    if (RX_BIT_EN)
    begin
      if (mark)
      begin
        if (seen_mark_q && RX_POS == last_pos_q && !RX_ZS_CODEWORD)
        begin
          bpv_d = 1'b1;
        end
        last_pos_d = RX_POS;
        seen_mark_d = 1'b1;
        zrun_d = 4'h0;
      end
      else if (zrun_q != EXZ_THRESH)
      begin
        zrun_d = zrun_q + 4'h1;
        exz_d = (zrun_q == EXZ_THRESH - 4'h1);
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      last_pos_q <= 1'b0;
      seen_mark_q <= 1'b0;
      zrun_q <= 4'h0;
      bpv_q <= 1'b0;
      exz_q <= 1'b0;
    end
    else
    begin
      last_pos_q <= last_pos_d;
      seen_mark_q <= seen_mark_d;
      zrun_q <= zrun_d;
      bpv_q <= bpv_d;
      exz_q <= exz_d;
    end
  end

  // ==========================================================
  // Framing and checksum sources
  logic lof;
  logic lof_start;
  logic frm_inc;
  logic crc_inc;

  perf_lof_monitor u_lof (
    .clk(CLK),
    .srst(SRST),
    .mf_done(MF_DONE),
    .mf_ok(MF_FAS_OK),
    .lof(lof),
    .lof_start(lof_start)
  );

  assign frm_inc = select_q ? (FBIT_ERR && !(gate_q && lof)) : lof_start;
  assign crc_inc = CRC_ERR && !(gate_q && lof);

  // ==========================================================
  // Counters
  logic [3:0] inc_vec;
  logic [CNT_W-1:0] snap [4];

  assign inc_vec = {crc_inc, frm_inc, exz_q, bpv_q};

  for (genvar i = 0; i < 4; i++)
  begin : g_cnt
    perf_sat_counter u_cnt (
      .clk(CLK),
      .srst(SRST),
      .inc(inc_vec[i]),
      .update(upd_q),
      .snap(snap[i])
    );
  end

  // ==========================================================
  // AXI4-Lite write channel
  logic aw_have_q;
  logic aw_have_d;
  logic w_have_q;
  logic w_have_d;
  logic awready_q;
  logic awready_d;
  logic wready_q;
  logic wready_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic [AXI_AW-1:0] waddr_d;
  logic [AXI_DW-1:0] wdata_d;
  logic [3:0] wstrb_d;

  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    wr_fire = 1'b0;
    if (AWVALID && awready_q)
    begin
      aw_have_d = 1'b1;
      waddr_d = AWADDR;
    end
    if (WVALID && wready_q)
    begin
      w_have_d = 1'b1;
      wdata_d = WDATA;
      wstrb_d = WSTRB;
    end
    if (aw_have_q && w_have_q && !bvalid_q)
    begin
      wr_fire = 1'b1;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (waddr_q == byte_addr(IDX_CTRL)) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_q && BREADY)
    begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [AXI_DW-1:0] rdata_q;
  logic [AXI_DW-1:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic lof_q;

  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && RREADY)
    begin
      rvalid_d = 1'b0;
    end
    if (ARVALID && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      case (ARADDR)
        byte_addr(IDX_BPV): rdata_d = {16'h0, snap[0]};
        byte_addr(IDX_EXZ): rdata_d = {16'h0, snap[1]};
        byte_addr(IDX_FRM): rdata_d = {16'h0, snap[2]};
        byte_addr(IDX_CRC): rdata_d = {16'h0, snap[3]};
        byte_addr(IDX_CTRL):
        begin
          rdata_d[CTRL_AUTO_BIT] = auto_q;
          rdata_d[CTRL_SELECT_BIT] = select_q;
          rdata_d[CTRL_GATE_BIT] = gate_q;
        end
        byte_addr(IDX_STAT): rdata_d[STAT_LOF_BIT] = lof;
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      lof_q <= 1'b0;
    end
    else
    begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      lof_q <= lof;
    end
  end

  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  assign LOF_STATE = lof_q;

endmodule

/* design/perf_cnt_pkg.sv */
// Constants, register map and helpers for the line performance error counters.
// Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
package perf_cnt_pkg;

  // ==========================================================
  // Widths
  localparam int CNT_W = 16;
  localparam int AXI_AW = 10;
  localparam int AXI_DW = 32;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BPV = 8'h18;
  localparam logic [7:0] IDX_EXZ = 8'h1a;
  localparam logic [7:0] IDX_FRM = 8'h1c;
  localparam logic [7:0] IDX_CRC = 8'h1e;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_STAT = 8'h21;

  // ==========================================================
  // Control register fields
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_MANUAL_BIT = 1;
  localparam int CTRL_SELECT_BIT = 2;
  localparam int CTRL_GATE_BIT = 3;
  localparam logic CTRL_AUTO_RST = 1'b1;
  localparam logic CTRL_SELECT_RST = 1'b0;
  localparam logic CTRL_GATE_RST = 1'b0;
  localparam int STAT_LOF_BIT = 0;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // Timing and thresholds
  localparam int CLK_PERIOD_NS = 10;
  localparam int UPDATE_PERIOD_MS = 1000;
  localparam int UPDATE_CYCLES = (UPDATE_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [3:0] EXZ_THRESH = 4'h8;
  localparam logic [2:0] LOF_SET_MF = 3'h7;
  localparam logic [2:0] LOF_CLR_MF = 3'h3;

  typedef enum logic {FRAME_OK, FRAME_LOST} frame_st_t;

  function automatic logic [AXI_AW-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

/* design/perf_sat_counter.sv */
// One saturating error counter with a host-visible snapshot.
// Assumes inc and update are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module perf_sat_counter
  import perf_cnt_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic inc,
  input wire logic update,
  output logic [CNT_W-1:0] snap
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] snap_q;
  logic [CNT_W-1:0] snap_d;
  logic [CNT_W-1:0] sum;

  // ==========================================================
  // Count and snapshot
  always_comb
  begin
    sum = (inc && cnt_q != CNT_MAX) ? cnt_q + 16'h0001 : cnt_q;
    cnt_d = update ? CNT_RST : sum;
    snap_d = update ? sum : snap_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q <= CNT_RST;
      snap_q <= CNT_RST;
    end
    else
    begin
      cnt_q <= cnt_d;
      snap_q <= snap_d;
    end
  end

  assign snap = snap_q;

endmodule

/* design/perf_lof_monitor.sv */
// Loss-of-frame tracker driven by per-multiframe alignment results.
// Assumes mf_done pulses once per received multiframe with mf_ok valid.
`timescale 1ns/1ps
module perf_lof_monitor
  import perf_cnt_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic mf_done,
  input wire logic mf_ok,
  output logic lof,
  output logic lof_start
);

  frame_st_t st_q;
  frame_st_t st_d;
  logic [2:0] run_q;
  logic [2:0] run_d;
  logic start_q;
  logic start_d;

  // ==========================================================
  // Bad and good multiframe runs
  always_comb
  begin
    st_d = st_q;
    run_d = run_q;
    start_d = 1'b0;
    if (mf_done)
    begin
      case (st_q)
        FRAME_OK:
        begin
          run_d = mf_ok ? 3'h0 : run_q + 3'h1;
          if (!mf_ok && run_q == LOF_SET_MF - 3'h1)
          begin
            st_d = FRAME_LOST;
            run_d = 3'h0;
            start_d = 1'b1;
          end
        end
        FRAME_LOST:
        begin
          run_d = mf_ok ? run_q + 3'h1 : 3'h0;
          if (mf_ok && run_q == LOF_CLR_MF - 3'h1)
          begin
            st_d = FRAME_OK;
            run_d = 3'h0;
          end
        end
        default:
        begin
          st_d = FRAME_OK;
          run_d = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= FRAME_OK;
      run_q <= 3'h0;
      start_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      run_q <= run_d;
      start_q <= start_d;
    end
  end

  assign lof = (st_q == FRAME_LOST);
  assign lof_start = start_q;

endmodule

/* verif/line_perf_chk.sv */
// Port assertions for the line performance counters.
// Assumes one clock domain and the synchronous reset SRST.
`timescale 1ns/1ps
module line_perf_chk
  import perf_cnt_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic MF_DONE,
  input wire logic MF_FAS_OK,
  input wire logic LOF_STATE,
  input wire logic [AXI_AW-1:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [AXI_AW-1:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [AXI_DW-1:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY
);
  // ==========================================================
  // Multiframe run counters
  logic [2:0] bad_q, bad_d, good_q, good_d;
  always_comb
  begin
    bad_d = bad_q;
    good_d = good_q;
    if (MF_DONE)
    begin
      bad_d = MF_FAS_OK ? 3'h0 : (bad_q == 3'h7 ? bad_q : bad_q + 3'h1);
      good_d = !MF_FAS_OK ? 3'h0 : (good_q == 3'h7 ? good_q : good_q + 3'h1);
    end
  end
  always_ff @(posedge CLK)
  begin
    bad_q <= SRST ? 3'h0 : bad_d;
    good_q <= SRST ? 3'h0 : good_d;
  end
  // ==========================================================
  // Properties
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  chk_lof_set: assert property (MF_DONE && !MF_FAS_OK && bad_q == 3'h6 |-> ##[1:3] LOF_STATE)
    else $error("Frame loss not declared");
  chk_lof_early: assert property ($rose(LOF_STATE) |-> bad_q == 3'h7)
    else $error("Frame loss too early");
  chk_lof_clear: assert property (MF_DONE && MF_FAS_OK && good_q == 3'h2 |-> ##[1:3] !LOF_STATE)
    else $error("Frame loss not cleared");
  chk_lof_keep: assert property ($fell(LOF_STATE) |-> good_q >= 3'h3)
    else $error("Frame loss cleared too early");
  chk_b_delay: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("Write response late");
  chk_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("Write response dropped");
  chk_r_delay: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("Read response late");
  chk_ro_write: assert property (AWVALID && AWREADY && WVALID && WREADY && AWADDR < 10'h80
    |-> ##2 BRESP == RESP_SLVERR)
    else $error("Counter write accepted");
  chk_bad_read: assert property (ARVALID && ARREADY && ARADDR > 10'h84
    |=> RRESP == RESP_SLVERR && RDATA == 32'h0)
    else $error("Unmapped read answered");
  chk_ar_busy: assert property (RVALID |-> !ARREADY)
    else $error("Address taken while busy");
  cover property ($fell(LOF_STATE));
  cover property (RVALID && RREADY && RDATA[15:0] == CNT_MAX);
  cover property (BVALID && BRESP == RESP_SLVERR);
endmodule
bind line_perf_counters line_perf_chk line_perf_chk_inst (.*);

/* verif/host_axi_model.sv */
// Host processor model: AXI4-Lite master reaching the counter registers.
// Assumes tasks are called by one process at a time.
`timescale 1ns/1ps
module host_axi_model
  import perf_cnt_pkg::*;
(
  input wire logic CLK,
  output logic [AXI_AW-1:0] AWADDR,
  output logic [2:0] AWPROT,
  output logic AWVALID,
  input wire logic AWREADY,
  output logic [AXI_DW-1:0] WDATA,
  output logic [3:0] WSTRB,
  output logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  output logic BREADY,
  output logic [AXI_AW-1:0] ARADDR,
  output logic [2:0] ARPROT,
  output logic ARVALID,
  input wire logic ARREADY,
  input wire logic [AXI_DW-1:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  output logic RREADY
);
  int lag = 0;
  initial
  begin
    AWADDR = '0;
    AWPROT = 3'h0;
    AWVALID = 1'b0;
    WDATA = '0;
    WSTRB = 4'hf;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARADDR = '0;
    ARPROT = 3'h0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
  end
  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d,
                    output logic [1:0] r);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (AWREADY)
        AWVALID <= 1'b0;
      if (WREADY)
        WVALID <= 1'b0;
    end
    while (BVALID !== 1'b1);
    repeat (lag) @(posedge CLK);
    BREADY <= 1'b1;
    @(posedge CLK);
    r = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [AXI_AW-1:0] a, output logic [AXI_DW-1:0] d,
                    output logic [1:0] r);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (ARREADY)
        ARVALID <= 1'b0;
    end
    while (RVALID !== 1'b1);
    repeat (lag) @(posedge CLK);
    RREADY <= 1'b1;
    @(posedge CLK);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask
endmodule

/* verif/test_line_perf_counters.sv */
// Self-checking bench for the line performance counters.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_line_perf_counters
  import perf_cnt_pkg::*;
;
  logic CLK;
  logic SRST = 1'b1;
  logic RX_BIT_EN = 1'b0, RX_POS = 1'b0, RX_NEG = 1'b0, RX_ZS_CODEWORD = 1'b0;
  logic MF_DONE = 1'b0, MF_FAS_OK = 1'b0, FBIT_ERR = 1'b0, CRC_ERR = 1'b0;
  logic COUNTER_UPDATE_PIN = 1'b0;
  logic LOF_STATE, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY;
  logic [AXI_AW-1:0] AWADDR, ARADDR;
  logic [AXI_DW-1:0] WDATA, RDATA;
  logic [2:0] AWPROT, ARPROT;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  int n_fail = 0;
  int tests_run = 0;
  line_perf_counters #(.UPDATE_CYCLES_P(50)) line_perf_counters_inst (.*);
  host_axi_model host_axi_model_inst (.*);
  // ==========================================================
  // Helpers
  task automatic rchk(input string nm, input logic [7:0] i, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host_axi_model_inst.rd({i, 2'b00}, d, r);
    `CHK(nm, {16'h0, e}, d)
  endtask
  task automatic wctl(input logic [3:0] c);
    logic [1:0] r;
    host_axi_model_inst.wr({IDX_CTRL, 2'b00}, {28'h0, c}, r);
    `CHK("ctrl write", RESP_OKAY, r)
    repeat (4) @(posedge CLK);
  endtask
  task automatic bits(input int c, input logic p, input logic n, input logic z);
    repeat (c)
    begin
      @(posedge CLK);
      RX_BIT_EN <= 1'b1;
      RX_POS <= p;
      RX_NEG <= n;
      RX_ZS_CODEWORD <= z;
      @(posedge CLK);
      RX_BIT_EN <= 1'b0;
    end
  endtask
  task automatic mf(input int c, input logic ok);
    repeat (c)
    begin
      @(posedge CLK);
      MF_DONE <= 1'b1;
      MF_FAS_OK <= ok;
      @(posedge CLK);
      MF_DONE <= 1'b0;
      repeat (2) @(posedge CLK);
    end
  endtask
  task automatic ev(input int c, input logic f, input logic e);
    repeat (c)
    begin
      @(posedge CLK);
      FBIT_ERR <= f;
      CRC_ERR <= e;
      @(posedge CLK);
      FBIT_ERR <= 1'b0;
      CRC_ERR <= 1'b0;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rchk("line count", IDX_BPV, 16'h0);
    rchk("zero count", IDX_EXZ, 16'h0);
    rchk("frame count", IDX_FRM, 16'h0);
    rchk("check count", IDX_CRC, 16'h0);
    rchk("control", IDX_CTRL, 16'h1);
    host_axi_model_inst.rd(10'h3f0, d, r);
    `CHK("unmapped read", RESP_SLVERR, r)
    host_axi_model_inst.wr({IDX_BPV, 2'b00}, 32'h1234, r);
    `CHK("counter write", RESP_SLVERR, r)
  endtask
  task automatic t_line();
    wctl(4'h0);
    bits(2, 1'b1, 1'b0, 1'b0);
    bits(1, 1'b1, 1'b0, 1'b1);
    bits(2, 1'b0, 1'b1, 1'b0);
    bits(20, 1'b0, 1'b0, 1'b0);
    bits(1, 1'b1, 1'b0, 1'b0);
    bits(7, 1'b0, 1'b0, 1'b0);
    bits(1, 1'b0, 1'b1, 1'b0);
    bits(8, 1'b0, 1'b0, 1'b0);
    bits(1, 1'b1, 1'b0, 1'b0);
    rchk("line before", IDX_BPV, 16'h0);
    wctl(4'h2);
    rchk("line count", IDX_BPV, 16'h2);
    rchk("zero count", IDX_EXZ, 16'h2);
    wctl(4'h2);
    rchk("line restart", IDX_BPV, 16'h0);
  endtask
  task automatic t_frame();
    mf(6, 1'b0);
    `CHK("lof early", 1'b0, LOF_STATE)
    mf(1, 1'b0);
    `CHK("lof set", 1'b1, LOF_STATE)
    rchk("status lof", IDX_STAT, 16'h1);
    ev(2, 1'b1, 1'b1);
    mf(5, 1'b0);
    mf(3, 1'b1);
    `CHK("lof clear", 1'b0, LOF_STATE)
    rchk("status clear", IDX_STAT, 16'h0);
    COUNTER_UPDATE_PIN <= 1'b1;
    repeat (8) @(posedge CLK);
    COUNTER_UPDATE_PIN <= 1'b0;
    rchk("frame lof", IDX_FRM, 16'h1);
    rchk("check ungated", IDX_CRC, 16'h2);
    wctl(4'hc);
    rchk("control set", IDX_CTRL, 16'hc);
    mf(7, 1'b0);
    ev(3, 1'b1, 1'b1);
    mf(3, 1'b1);
    ev(1, 1'b1, 1'b1);
    wctl(4'he);
    rchk("frame gated", IDX_FRM, 16'h1);
    rchk("check gated", IDX_CRC, 16'h1);
    wctl(4'h4);
    mf(7, 1'b0);
    ev(2, 1'b1, 1'b1);
    mf(3, 1'b1);
    wctl(4'h6);
    rchk("frame fbit", IDX_FRM, 16'h2);
    rchk("check count", IDX_CRC, 16'h2);
  endtask
  task automatic t_sat_auto();
    wctl(4'h0);
    CRC_ERR <= 1'b1;
    repeat (65540) @(posedge CLK);
    CRC_ERR <= 1'b0;
    wctl(4'h2);
    rchk("check full", IDX_CRC, CNT_MAX);
    host_axi_model_inst.lag = 2;
    wctl(4'h1);
    ev(3, 1'b0, 1'b1);
    repeat (60) @(posedge CLK);
    rchk("check auto", IDX_CRC, 16'h3);
    repeat (110) @(posedge CLK);
    rchk("check next", IDX_CRC, 16'h0);
  endtask
  // ==========================================================
  // Run control
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial
  begin
    repeat (90000) @(posedge CLK);
    n_fail++;
    test_done();
  end
  initial
  begin
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    t_reset();
    t_line();
    t_frame();
    t_sat_auto();
    test_done();
  end
endmodule
